// file: tcr_pkg.sv
// shared constants and carrier types of the tuner control register bank
package tcr_pkg;

	// register byte addresses on the serial bus
	localparam logic [7:0] ADDR_OSC_CTRL   = 8'h09;
	localparam logic [7:0] ADDR_BB_CTRL    = 8'h0A;
	localparam logic [7:0] ADDR_OFS_CTRL   = 8'h0B;
	localparam logic [7:0] ADDR_OFS_VALUE  = 8'h0C;
	localparam logic [7:0] ADDR_TBL_PTR    = 8'h0D;
	localparam logic [7:0] ADDR_TBL_READ   = 8'h10;

	// reset values of the writable registers, and the byte read at unmapped addresses
	localparam logic [7:0] RST_OSC_CTRL    = 8'h00;
	localparam logic [7:0] RST_BB_CTRL     = 8'h00;
	localparam logic [7:0] RST_OFS_CTRL    = 8'h00;
	localparam logic [7:0] RST_OFS_VALUE   = 8'h00;
	localparam logic [7:0] RST_TBL_PTR     = 8'h00;
	localparam logic [7:0] UNMAPPED_READ   = 8'h00;

	// oscillator_control fields
	localparam int OSC_SEL_LSB    = 6;
	localparam int SUB_BAND_LSB   = 3;
	localparam int AUTO_TUNE_BIT  = 2;
	localparam int CONV_LATCH_BIT = 1;
	localparam int CONV_READ_BIT  = 0;

	// baseband_control fields
	localparam int BW_LSB         = 4;
	localparam int BIAS_BIT       = 3;
	localparam int ATTACK_LSB     = 0;

	// offset_correction_control fields
	localparam int OFS_MSB_BIT    = 6;
	localparam int OFS_MODE_LSB   = 4;
	localparam int OFS_SPEED_LSB  = 2;
	localparam int OFS_THR_LSB    = 0;

	// table_pointer field
	localparam int TBL_PTR_LSB    = 0;

	// field codes
	localparam logic [1:0] OSC_OFF        = 2'h0;
	localparam logic [1:0] OFS_MODE_OFF   = 2'h0;
	localparam logic [1:0] OFS_MODE_AUTO  = 2'h3;
	localparam logic [1:0] OFS_SPEED_HOLD = 2'h0;
	localparam logic [3:0] TBL_TRACKING   = 4'h1;
	localparam logic [3:0] TBL_BALUN      = 4'h2;
	localparam logic [3:0] TBL_BANDWIDTH  = 4'h3;

	typedef enum logic [1:0] {
		OFS_OFF,
		OFS_MANUAL,
		OFS_AUTO
	} tcr_ofs_mode_e;

	// one accepted data byte from the serial protocol engine
	typedef struct packed {
		logic       strobe;
		logic [7:0] addr;
		logic [7:0] data;
	} tcr_wr_s;

	typedef struct packed {
		logic [3:0] bandwidth;
		logic       biasHigh;
		logic [2:0] attackPoint;
	} tcr_bb_s;

	typedef struct packed {
		tcr_ofs_mode_e mode;
		logic [1:0]    speed;
		logic          holdDac;
		logic [1:0]    threshold;
	} tcr_ofs_s;

endpackage

// file: tcr_coef_table.sv
// read-only coefficient table addressed by the table pointer
`timescale 1ns/1ps
module tcr_coef_table #(
	parameter logic [7:0] TRACKING_ENTRY  = 8'h00,
	parameter logic [7:0] BALUN_ENTRY     = 8'h00,
	parameter logic [7:0] BANDWIDTH_ENTRY = 8'h00
) (
	input  wire logic [3:0] pointer,
	output logic      [7:0] entry
);

	// reserved codes read as zero
	always_comb
	begin
		unique case (pointer)
			tcr_pkg::TBL_TRACKING:  entry = TRACKING_ENTRY;
			tcr_pkg::TBL_BALUN:     entry = BALUN_ENTRY;
			tcr_pkg::TBL_BANDWIDTH: entry = BANDWIDTH_ENTRY;
			default:                entry = 8'h00;
		endcase
	end

endmodule

// file: tcr_control_regs.sv
// tuner control register bank with decoded control outputs
`timescale 1ns/1ps

// Functional notes
// - manual oscillator select: off, low, mid, high
// - manual sub-band select 0..7 binary order
// - auto-tune bit hands selection to autotuner
// - latch bit holds converter output, manual only
// - read bit enables converter read, manual only
// - bandwidth field drives baseband filter bandwidth
// - bias bit selects high or low bias
// - attack point field; 000 most aggressive
// - control bit 6 is offset value MSB
// - value register gives low eight bits
// - offset mode: off, manual load, automatic
// - speed 00 holds DACs in automatic mode; others set speed
// - threshold field selects residual offset target
// - table pointer selects coefficient table entry
// - selected table entry appears in readback register
// - main bias shutdown needs shutdown-all set, manual oscillator field off, offset mode off
module tcr_control_regs #(
	parameter logic [7:0] TRACKING_ENTRY  = 8'h00,
	parameter logic [7:0] BALUN_ENTRY     = 8'h00,
	parameter logic [7:0] BANDWIDTH_ENTRY = 8'h00
) (
	input  wire logic                   sys_clk,
	input  wire logic                   sys_rst,
	input  wire tcr_pkg::tcr_wr_s       wrReq,
	input  wire logic [7:0]             rdAddr,
	output logic      [7:0]             rdData,
	input  wire logic [1:0]             autoOscSelect,
	input  wire logic [2:0]             autoSubBand,
	input  wire logic [2:0]             converterPin,
	input  wire logic [8:0]             autoDacI,
	input  wire logic [8:0]             autoDacQ,
	input  wire logic                   shutdownAllSet,
	output logic      [2:0]             oscEnable,
	output logic      [2:0]             subBand,
	output logic                        autoTuneActive,
	output logic                        converterReadEnable,
	output logic                        converterLatchEnable,
	output logic      [2:0]             tuningReading,
	output tcr_pkg::tcr_bb_s            bbCtrl,
	output tcr_pkg::tcr_ofs_s           ofsCtrl,
	output logic      [8:0]             dacI,
	output logic      [8:0]             dacQ,
	output logic      [7:0]             tableReadValue,
	output logic                        mainBiasMayShutdown
);

	logic [7:0]           oscillatorControl;
	logic [7:0]           basebandControl;
	logic [7:0]           offsetCorrectionControl;
	logic [7:0]           offsetCorrectionValue;
	logic [7:0]           tablePointer;
	logic [7:0]           tableEntry;
	logic [2:0]           convMeta;
	logic [2:0]           convSync;
	logic [1:0]           oscSelect;
	logic [8:0]           manualOffset;
	tcr_pkg::tcr_ofs_mode_e ofsMode;
	logic [7:0]           next_rdData;
	logic [2:0]           next_oscEnable;
	logic [2:0]           next_subBand;
	logic [8:0]           next_dacI;
	logic [8:0]           next_dacQ;

	// write of one byte lands on the edge after its strobe
	function automatic logic hit(input tcr_pkg::tcr_wr_s req, input logic [7:0] addr);
		hit = req.strobe && (req.addr == addr);
	endfunction

	function automatic tcr_pkg::tcr_ofs_mode_e decode_mode(input logic [1:0] code);
		unique case (code)
			tcr_pkg::OFS_MODE_OFF:  decode_mode = tcr_pkg::OFS_OFF;
			tcr_pkg::OFS_MODE_AUTO: decode_mode = tcr_pkg::OFS_AUTO;
			default:                decode_mode = tcr_pkg::OFS_MANUAL;
		endcase
	endfunction

	// register storage
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			oscillatorControl <= tcr_pkg::RST_OSC_CTRL;
		end
		else if (hit(wrReq, tcr_pkg::ADDR_OSC_CTRL))
		begin
			oscillatorControl <= wrReq.data;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			basebandControl <= tcr_pkg::RST_BB_CTRL;
		end
		else if (hit(wrReq, tcr_pkg::ADDR_BB_CTRL))
		begin
			basebandControl <= wrReq.data;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			offsetCorrectionControl <= tcr_pkg::RST_OFS_CTRL;
		end
		else if (hit(wrReq, tcr_pkg::ADDR_OFS_CTRL))
		begin
			// top bit is stored as written; host keeps it zero
			offsetCorrectionControl <= wrReq.data;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			offsetCorrectionValue <= tcr_pkg::RST_OFS_VALUE;
		end
		else if (hit(wrReq, tcr_pkg::ADDR_OFS_VALUE))
		begin
			offsetCorrectionValue <= wrReq.data;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			tablePointer <= tcr_pkg::RST_TBL_PTR;
		end
		else if (hit(wrReq, tcr_pkg::ADDR_TBL_PTR))
		begin
			// upper nibble stored as written; host keeps it zero
			tablePointer <= wrReq.data;
		end
	end

	// coefficient table lookup
	tcr_coef_table #(
		.TRACKING_ENTRY  (TRACKING_ENTRY),
		.BALUN_ENTRY     (BALUN_ENTRY),
		.BANDWIDTH_ENTRY (BANDWIDTH_ENTRY)
	) coefTable (
		.pointer (tablePointer[tcr_pkg::TBL_PTR_LSB +: 4]),
		.entry   (tableEntry)
	);

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			tableReadValue <= 8'h00;
		end
		else
		begin
			tableReadValue <= tableEntry;
		end
	end

	// register readback
	always_comb
	begin
		unique case (rdAddr)
			tcr_pkg::ADDR_OSC_CTRL:  next_rdData = oscillatorControl;
			tcr_pkg::ADDR_BB_CTRL:   next_rdData = basebandControl;
			tcr_pkg::ADDR_OFS_CTRL:  next_rdData = offsetCorrectionControl;
			tcr_pkg::ADDR_OFS_VALUE: next_rdData = offsetCorrectionValue;
			tcr_pkg::ADDR_TBL_PTR:   next_rdData = tablePointer;
			tcr_pkg::ADDR_TBL_READ:  next_rdData = tableReadValue;
			default:                 next_rdData = tcr_pkg::UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			rdData <= tcr_pkg::UNMAPPED_READ;
		end
		else
		begin
			rdData <= next_rdData;
		end
	end

	// oscillator and sub-band selection
	always_comb
	begin
		autoTuneActive = oscillatorControl[tcr_pkg::AUTO_TUNE_BIT];
		if (autoTuneActive)
		begin
			oscSelect    = autoOscSelect;
			next_subBand = autoSubBand;
		end
		else
		begin
			oscSelect    = oscillatorControl[tcr_pkg::OSC_SEL_LSB +: 2];
			next_subBand = oscillatorControl[tcr_pkg::SUB_BAND_LSB +: 3];
		end
		unique case (oscSelect)
			2'h0:    next_oscEnable = 3'h0;
			2'h1:    next_oscEnable = 3'h1;
			2'h2:    next_oscEnable = 3'h2;
			2'h3:    next_oscEnable = 3'h4;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			oscEnable <= 3'h0;
			subBand   <= 3'h0;
		end
		else
		begin
			oscEnable <= next_oscEnable;
			subBand   <= next_subBand;
		end
	end

	// tuning-voltage converter read and latch
	always_comb
	begin
		converterReadEnable  = !autoTuneActive && oscillatorControl[tcr_pkg::CONV_READ_BIT];
		converterLatchEnable = !autoTuneActive && oscillatorControl[tcr_pkg::CONV_LATCH_BIT];
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			convMeta <= 3'h0;
			convSync <= 3'h0;
		end
		else
		begin
			convMeta <= converterPin;
			convSync <= convMeta;
		end
	end

	// latch set freezes the reading; otherwise it follows while reads are on
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			tuningReading <= 3'h0;
		end
		else if (converterReadEnable && !converterLatchEnable)
		begin
			tuningReading <= convSync;
		end
	end

	// baseband filter and detector controls
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			bbCtrl <= '0;
		end
		else
		begin
			bbCtrl.bandwidth   <= basebandControl[tcr_pkg::BW_LSB +: 4];
			bbCtrl.biasHigh    <= basebandControl[tcr_pkg::BIAS_BIT];
			bbCtrl.attackPoint <= basebandControl[tcr_pkg::ATTACK_LSB +: 3];
		end
	end

	// offset correction controls
	always_comb
	begin
		manualOffset = {offsetCorrectionControl[tcr_pkg::OFS_MSB_BIT], offsetCorrectionValue};
		ofsMode      = decode_mode(offsetCorrectionControl[tcr_pkg::OFS_MODE_LSB +: 2]);
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			ofsCtrl.mode      <= tcr_pkg::OFS_OFF;
			ofsCtrl.speed     <= tcr_pkg::OFS_SPEED_HOLD;
			ofsCtrl.holdDac   <= 1'b1;
			ofsCtrl.threshold <= 2'h0;
		end
		else
		begin
			ofsCtrl.mode      <= ofsMode;
			ofsCtrl.speed     <= offsetCorrectionControl[tcr_pkg::OFS_SPEED_LSB +: 2];
			ofsCtrl.holdDac   <= offsetCorrectionControl[tcr_pkg::OFS_SPEED_LSB +: 2] == tcr_pkg::OFS_SPEED_HOLD;
			ofsCtrl.threshold <= offsetCorrectionControl[tcr_pkg::OFS_THR_LSB +: 2];
		end
	end

	// DAC words: off clears, manual loads both, auto tracks unless held
	always_comb
	begin
		next_dacI = dacI;
		next_dacQ = dacQ;
		unique case (ofsMode)
			tcr_pkg::OFS_OFF:
			begin
				next_dacI = 9'h000;
				next_dacQ = 9'h000;
			end
			tcr_pkg::OFS_MANUAL:
			begin
				next_dacI = manualOffset;
				next_dacQ = manualOffset;
			end
			tcr_pkg::OFS_AUTO:
			begin
				if (offsetCorrectionControl[tcr_pkg::OFS_SPEED_LSB +: 2] != tcr_pkg::OFS_SPEED_HOLD)
				begin
					next_dacI = autoDacI;
					next_dacQ = autoDacQ;
				end
			end
			default:
			begin
				next_dacI = 9'h000;
				next_dacQ = 9'h000;
			end
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			dacI <= 9'h000;
			dacQ <= 9'h000;
		end
		else
		begin
			dacI <= next_dacI;
			dacQ <= next_dacQ;
		end
	end

	// main bias shutdown permission
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			mainBiasMayShutdown <= 1'b0;
		end
		else
		begin
			mainBiasMayShutdown <= shutdownAllSet
				&& oscillatorControl[tcr_pkg::OSC_SEL_LSB +: 2] == tcr_pkg::OSC_OFF
				&& offsetCorrectionControl[tcr_pkg::OFS_MODE_LSB +: 2] == tcr_pkg::OFS_MODE_OFF;
		end
	end

endmodule

// file: tcr_control_regs_asserts.sv
// concurrent checks on the ports of the tuner control register bank
`timescale 1ns/1ps
module tcr_control_regs_asserts (
	input wire logic              sys_clk,
	input wire logic              sys_rst,
	input wire tcr_pkg::tcr_wr_s  wrReq,
	input wire logic [7:0]        rdAddr,
	input wire logic [7:0]        rdData,
	input wire logic [2:0]        autoSubBand,
	input wire logic              shutdownAllSet,
	input wire logic [2:0]        oscEnable,
	input wire logic [2:0]        subBand,
	input wire logic              autoTuneActive,
	input wire logic              converterReadEnable,
	input wire logic              converterLatchEnable,
	input wire tcr_pkg::tcr_bb_s  bbCtrl,
	input wire tcr_pkg::tcr_ofs_s ofsCtrl,
	input wire logic [8:0]        dacI,
	input wire logic              mainBiasMayShutdown
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	function automatic logic [2:0] hot(logic [1:0] s);
		return (s == 2'h0) ? 3'h0 : 3'(1 << (s - 2'h1));
	endfunction
	// write to one address, not rewritten the next cycle
	sequence s_wr(logic [7:0] a);
		wrReq.strobe && wrReq.addr == a ##1 !(wrReq.strobe && wrReq.addr == a);
	endsequence
	property p_osc;
		s_wr(tcr_pkg::ADDR_OSC_CTRL) |=> $past(wrReq.data[2], 2) ||
			(oscEnable == hot($past(wrReq.data[7:6], 2)) && subBand == $past(wrReq.data[5:3], 2));
	endproperty
	a_osc: assert property (p_osc) else $error("manual oscillator or sub-band wrong");
	property p_conv;
		wrReq.strobe && wrReq.addr == tcr_pkg::ADDR_OSC_CTRL |=> autoTuneActive == $past(wrReq.data[2]) &&
			converterReadEnable == (!$past(wrReq.data[2]) && $past(wrReq.data[0])) &&
			converterLatchEnable == (!$past(wrReq.data[2]) && $past(wrReq.data[1]));
	endproperty
	a_conv: assert property (p_conv) else $error("converter enables wrong");
	property p_auto;
		autoTuneActive |=> subBand == $past(autoSubBand);
	endproperty
	a_auto: assert property (p_auto) else $error("autotuner sub-band not followed");
	property p_bb;
		s_wr(tcr_pkg::ADDR_BB_CTRL) |=> bbCtrl == $past(wrReq.data, 2);
	endproperty
	a_bb: assert property (p_bb) else $error("baseband controls wrong");
	property p_ofs;
		s_wr(tcr_pkg::ADDR_OFS_CTRL) |=> ofsCtrl.speed == $past(wrReq.data[3:2], 2) &&
			ofsCtrl.threshold == $past(wrReq.data[1:0], 2) &&
			ofsCtrl.holdDac == ($past(wrReq.data[3:2], 2) == 2'h0) &&
			(ofsCtrl.mode == tcr_pkg::OFS_OFF) == ($past(wrReq.data[5:4], 2) == 2'h0);
	endproperty
	a_ofs: assert property (p_ofs) else $error("offset controls wrong");
	property p_off;
		ofsCtrl.mode == tcr_pkg::OFS_OFF |-> dacI == 9'h000;
	endproperty
	a_off: assert property (p_off) else $error("offset dac not zero when off");
	property p_bias;
		mainBiasMayShutdown |-> $past(shutdownAllSet) && ofsCtrl.mode == tcr_pkg::OFS_OFF;
	endproperty
	a_bias: assert property (p_bias) else $error("main bias shutdown allowed wrongly");
	property p_rdback;
		wrReq.strobe && wrReq.addr inside {[8'h09:8'h0D]} ##1 rdAddr == $past(wrReq.addr) && !wrReq.strobe
			|=> rdData == $past(wrReq.data, 2);
	endproperty
	a_rdback: assert property (p_rdback) else $error("written byte not read back");
	property p_unmapped;
		!(rdAddr inside {[8'h09:8'h0D], 8'h10}) |=> rdData == tcr_pkg::UNMAPPED_READ;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind tcr_control_regs tcr_control_regs_asserts u_chk (
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.wrReq(wrReq),
	.rdAddr(rdAddr),
	.rdData(rdData),
	.autoSubBand(autoSubBand),
	.shutdownAllSet(shutdownAllSet),
	.oscEnable(oscEnable),
	.subBand(subBand),
	.autoTuneActive(autoTuneActive),
	.converterReadEnable(converterReadEnable),
	.converterLatchEnable(converterLatchEnable),
	.bbCtrl(bbCtrl),
	.ofsCtrl(ofsCtrl),
	.dacI(dacI),
	.mainBiasMayShutdown(mainBiasMayShutdown)
);

// file: tcr_host_model.sv
// host model issuing accepted write bytes and register reads
`timescale 1ns/1ps
module tcr_host_model (
	input  wire logic        sys_clk,
	output tcr_pkg::tcr_wr_s wrReq,
	output logic [7:0]       rdAddr,
	input  wire logic [7:0]  rdData
);
	initial
	begin
		wrReq = '0;
		rdAddr = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] m;
		m = d;
		if (a == tcr_pkg::ADDR_TBL_PTR)
			m[7:4] = 4'h0;
		if (a == tcr_pkg::ADDR_OFS_CTRL)
			m[7] = 1'b0;
		@(posedge sys_clk);
		#1;
		wrReq = {1'b1, a, m};
		@(posedge sys_clk);
		#1;
		// unqualified bus shows inverted junk
		wrReq = {1'b0, ~a, ~m};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		rdAddr = a;
		@(posedge sys_clk);
		#1;
		d = rdData;
	endtask
endmodule

// file: tcr_control_regs_tb_top.sv
// self-checking bench for the tuner control register bank
`timescale 1ns/1ps
module tcr_control_regs_tb_top;
	logic              sys_clk = 1'b0;
	logic              sys_rst = 1'b1;
	tcr_pkg::tcr_wr_s  wrReq;
	logic [7:0]        rdAddr;
	logic [7:0]        rdData;
	logic [1:0]        autoOscSelect = 2'h3;
	logic [2:0]        autoSubBand = 3'h6;
	logic [2:0]        converterPin = 3'h5;
	logic [8:0]        autoDacI = 9'h000;
	logic [8:0]        autoDacQ = 9'h000;
	logic              shutdownAllSet = 1'b0;
	logic [2:0]        oscEnable;
	logic [2:0]        subBand;
	logic              autoTuneActive;
	logic              converterReadEnable;
	logic              converterLatchEnable;
	logic [2:0]        tuningReading;
	tcr_pkg::tcr_bb_s  bbCtrl;
	tcr_pkg::tcr_ofs_s ofsCtrl;
	logic [8:0]        dacI;
	logic [8:0]        dacQ;
	logic [7:0]        tableReadValue;
	logic              mainBiasMayShutdown;
	int                errTotal = 0;
	int                checks = 0;
	int                cycles = 0;
	logic [7:0]        v;
	logic [7:0]        d;
	logic [2:0]        hotExp [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
	logic [7:0]        tblExp [5] = '{8'h00, 8'hA1, 8'hB2, 8'hC3, 8'h00};
	logic [7:0]        oc [5] = '{8'hD5, 8'h25, 8'h3A, 8'h33, 8'h0D};
	logic [8:0]        ad [5] = '{9'h000, 9'h000, 9'h1A3, 9'h0F0, 9'h0F0};
	logic [8:0]        ed [5] = '{9'h155, 9'h055, 9'h1A3, 9'h1A3, 9'h000};
	tcr_pkg::tcr_ofs_mode_e em;
	always #10 sys_clk = ~sys_clk;
	tcr_control_regs #(
		.TRACKING_ENTRY(8'hA1),
		.BALUN_ENTRY(8'hB2),
		.BANDWIDTH_ENTRY(8'hC3)
	) DUT (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.wrReq(wrReq),
		.rdAddr(rdAddr),
		.rdData(rdData),
		.autoOscSelect(autoOscSelect),
		.autoSubBand(autoSubBand),
		.converterPin(converterPin),
		.autoDacI(autoDacI),
		.autoDacQ(autoDacQ),
		.shutdownAllSet(shutdownAllSet),
		.oscEnable(oscEnable),
		.subBand(subBand),
		.autoTuneActive(autoTuneActive),
		.converterReadEnable(converterReadEnable),
		.converterLatchEnable(converterLatchEnable),
		.tuningReading(tuningReading),
		.bbCtrl(bbCtrl),
		.ofsCtrl(ofsCtrl),
		.dacI(dacI),
		.dacQ(dacQ),
		.tableReadValue(tableReadValue),
		.mainBiasMayShutdown(mainBiasMayShutdown)
	);
	tcr_host_model host (
		.sys_clk(sys_clk),
		.wrReq(wrReq),
		.rdAddr(rdAddr),
		.rdData(rdData)
	);
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		checks++;
		if (got !== exp)
		begin
			errTotal++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] r;
		host.rd(a, r);
		chk(9'(r), 9'(e));
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", checks, errTotal);
		if (errTotal == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errTotal++;
			close_out();
		end
	end
	initial
	begin
		step(16);
		sys_rst = 1'b0;
		for (int i = 0; i < 5; i++)
			rdc(8'h09 + 8'(i), 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			v = {i[1:0], i[2:0], 3'h1};
			host.wr(tcr_pkg::ADDR_OSC_CTRL, v);
			rdc(tcr_pkg::ADDR_OSC_CTRL, v);
			chk(9'(oscEnable), 9'(hotExp[i % 4]));
			chk(9'(subBand), 9'(i[2:0]));
			chk(9'(converterReadEnable), 9'h001);
		end
		step(4);
		chk(9'(tuningReading), 9'h005);
		host.wr(tcr_pkg::ADDR_OSC_CTRL, 8'h03);
		step(1);
		converterPin = 3'h2;
		step(4);
		chk(9'(tuningReading), 9'h005);
		host.wr(tcr_pkg::ADDR_OSC_CTRL, 8'h07);
		step(1);
		chk(9'(autoTuneActive), 9'h001);
		chk(9'(subBand), 9'h006);
		chk(9'(oscEnable), 9'h004);
		chk(9'({converterReadEnable, converterLatchEnable}), 9'h000);
		for (int p = 0; p < 5; p++)
		begin
			host.wr(tcr_pkg::ADDR_TBL_PTR, 8'hF0 | 8'(p));
			rdc(tcr_pkg::ADDR_TBL_PTR, 8'(p));
			rdc(tcr_pkg::ADDR_TBL_READ, tblExp[p]);
			chk(9'(tableReadValue), 9'(tblExp[p]));
		end
		host.wr(tcr_pkg::ADDR_TBL_PTR, 8'h03);
		step(1);
		host.rd(tcr_pkg::ADDR_TBL_READ, d);
		for (int k = 0; k < 2; k++)
		begin
			v = (k == 0) ? {d[3:0], 4'h8} : 8'h97;
			host.wr(tcr_pkg::ADDR_BB_CTRL, v);
			step(1);
			chk(9'(bbCtrl), 9'(v));
		end
		host.wr(tcr_pkg::ADDR_OFS_VALUE, 8'h55);
		for (int k = 0; k < 5; k++)
		begin
			host.wr(tcr_pkg::ADDR_OFS_CTRL, oc[k]);
			autoDacI = ad[k];
			autoDacQ = ad[k];
			rdc(tcr_pkg::ADDR_OFS_CTRL, oc[k] & 8'h7F);
			step(1);
			em = (oc[k][5:4] == 2'h0) ? tcr_pkg::OFS_OFF : (oc[k][5:4] == 2'h3) ? tcr_pkg::OFS_AUTO : tcr_pkg::OFS_MANUAL;
			chk(9'(ofsCtrl.mode), 9'(em));
			chk(dacI, ed[k]);
			chk(dacQ, ed[k]);
		end
		shutdownAllSet = 1'b1;
		step(2);
		chk(9'(mainBiasMayShutdown), 9'h001);
		host.wr(tcr_pkg::ADDR_OSC_CTRL, 8'h40);
		step(2);
		chk(9'(mainBiasMayShutdown), 9'h000);
		host.wr(8'h0E, 8'hFF);
		host.wr(tcr_pkg::ADDR_TBL_READ, 8'hFF);
		rdc(8'h0E, 8'h00);
		rdc(tcr_pkg::ADDR_TBL_READ, 8'hC3);
		close_out();
	end
endmodule
